/* File: tccm_params.svh */
`ifndef TCCM_PARAMS_SVH
`define TCCM_PARAMS_SVH

// ----------------------------------------
// register offsets and reset value
// ----------------------------------------
`define TCCM_OFS_CH1 8'h08
`define TCCM_OFS_CH2 8'h09
`define TCCM_CFG_RESET 8'h00

// ----------------------------------------
// field positions of a mode byte
// ----------------------------------------
`define TCCM_CLEAR_BIT 7
`define TCCM_MODE_MSB 6
`define TCCM_MODE_LSB 4
`define TCCM_PRELOAD_BIT 3
`define TCCM_FAST_BIT 2
`define TCCM_DIR_MSB 1
`define TCCM_DIR_LSB 0

// ----------------------------------------
// field values and timing counts
// ----------------------------------------
`define TCCM_DIR_OUT 2'h0
`define TCCM_DIR_OWN 2'h1
`define TCCM_DIR_OTHER 2'h2
`define TCCM_DIR_TRIG 2'h3
`define TCCM_LOCK_FULL 2'h3
`define TCCM_FAST_DELAY 3

`endif

/* File: tccm_pkg.sv */
package tccm_pkg;

   // compare reference modes
   typedef enum logic [2:0] {
      TCCM_FROZEN = 3'h0,
      TCCM_MATCH_HIGH = 3'h1,
      TCCM_MATCH_LOW = 3'h2,
      TCCM_TOGGLE = 3'h3,
      TCCM_FORCE_LOW = 3'h4,
      TCCM_FORCE_HIGH = 3'h5,
      TCCM_PWM1 = 3'h6,
      TCCM_PWM2 = 3'h7
   } tccm_mode_t;

   // mode byte seen with the channel as output
   typedef struct packed {
      logic extClearEn;
      tccm_mode_t compareMode;
      logic comparePreloadEn;
      logic fastTriggerEn;
      logic [1:0] directionSelect;
   } tccm_out_cfg_t;

   // mode byte seen with the channel as input
   typedef struct packed {
      logic [3:0] inputFilter;
      logic [1:0] capturePrescale;
      logic [1:0] directionSelect;
   } tccm_in_cfg_t;

   // status coming from the surrounding timer core
   typedef struct packed {
      logic [15:0] counterValue;
      logic countDown;
      logic updateEvent;
      logic commutationEvent;
      logic controlPreloadSelect;
      logic [1:0] lockLevel;
      logic triggerEdge;
      logic internalTriggerInput;
      logic internalTriggerSelected;
      logic filteredExternalTrigger;
   } tccm_timer_t;

   // active enable and polarity bits of one channel
   typedef struct packed {
      logic complementEnable;
      logic polarity;
      logic enable;
   } tccm_chan_en_t;

   // consecutive samples needed per filter code
   function automatic logic [3:0] tccm_filter_len(input logic [3:0] code);
      logic [3:0] n;
      n = 4'h8;
      unique case (code)
         4'h0: n = 4'h1;
         4'h1: n = 4'h2;
         4'h2: n = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hB, 4'hE: n = 4'h6;
         4'hA, 4'hD: n = 4'h5;
         default: n = 4'h8;
      endcase
      return n;
   endfunction

   // sampling divider mask per filter code
   function automatic logic [4:0] tccm_filter_mask(input logic [3:0] code);
      logic [4:0] m;
      m = 5'h00;
      if (code >= 4'hD) begin
         m = 5'h1F;
      end else if (code >= 4'hA) begin
         m = 5'h0F;
      end else if (code >= 4'h8) begin
         m = 5'h07;
      end else if (code >= 4'h6) begin
         m = 5'h03;
      end else if (code >= 4'h4) begin
         m = 5'h01;
      end
      return m;
   endfunction

endpackage

/* File: tccm_mode_config.sv */
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "tccm_params.svh"

module tccm_mode_config (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // compare value write port, one strobe per channel
   input wire logic [1:0] cmpWr,
   input wire logic [15:0] cmpWdata,
   output logic [1:0][15:0] compareReadback,
   output logic [1:0][15:0] activeCompare,
   // timer core status and channel enables
   input wire tccm_pkg::tccm_timer_t timerStat,
   input wire tccm_pkg::tccm_chan_en_t [1:0] chanEn,
   // channel input pins, asynchronous
   input wire logic [1:0] chPin,
   // channel results
   output logic [1:0] compareReference,
   output logic [1:0] chOutput,
   output logic [1:0] filteredInput,
   output logic [1:0] capturePulse
);
   import tccm_pkg::*;

   // ----------------------------------------
   // shared timing: sampling divider, trigger pipe
   // ----------------------------------------

   // free-running divider, its low bits give every slower rate
   logic [4:0] divCnt;
   // delayed trigger edge for the fast path
   logic [`TCCM_FAST_DELAY-2:0] trigPipe;
   // pending read data
   logic [7:0] next_regRdata;
   // stored mode bytes, one per channel
   logic [1:0][7:0] cfgReg;

   // divider keeps running, a filter only looks at its low bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         divCnt <= 5'h00;
      end else begin
         divCnt <= divCnt + 5'h01;
      end
   end

   // two stages plus the reference flop make three cycles
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trigPipe <= '0;
      end else begin
         trigPipe <= {trigPipe[`TCCM_FAST_DELAY-3:0], timerStat.triggerEdge};
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------

   // unmapped addresses read as zero
   wire hitCh1 = (regAddr == `TCCM_OFS_CH1);
   wire hitCh2 = (regAddr == `TCCM_OFS_CH2);
   assign next_regRdata = !regRd ? 8'h00 :
                          hitCh1 ? cfgReg[0] :
                          hitCh2 ? cfgReg[1] : 8'h00;

   // data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= next_regRdata;
      end
   end

   // ----------------------------------------
   // per-channel logic
   // ----------------------------------------

   logic [1:0] pinMeta;
   logic [1:0] pinSync;

   // pin synchroniser, first stage read only by the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pinMeta <= 2'h0;
         pinSync <= 2'h0;
      end else begin
         pinMeta <= chPin;
         pinSync <= pinMeta;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_chan
         // views of the stored byte
         tccm_out_cfg_t outCfg;
         tccm_in_cfg_t inCfg;
         tccm_mode_t activeMode;
         tccm_mode_t prevMode;
         tccm_mode_t next_mode;
         logic [7:0] next_cfg;
         logic [15:0] preloadCmp;
         logic [3:0] filtCnt;
         logic [2:0] pscCnt;
         logic srcPrev;
         logic refLvl;
         logic lastPwm;
         logic next_ref;

         assign outCfg = tccm_out_cfg_t'(cfgReg[i]);
         assign inCfg = tccm_in_cfg_t'(cfgReg[i]);

         // ---- register write with its guards ----
         wire wrHit = regWr &&
            (regAddr == ((i == 0) ? `TCCM_OFS_CH1 : `TCCM_OFS_CH2));
         wire dirOpen = (i == 0) ? !chanEn[i].enable :
            (!chanEn[i].enable && !chanEn[i].complementEnable);
         wire lockShut = (timerStat.lockLevel == `TCCM_LOCK_FULL) &&
            (outCfg.directionSelect == `TCCM_DIR_OUT);

         assign next_cfg = {
            regWdata[`TCCM_CLEAR_BIT],
            lockShut ? cfgReg[i][`TCCM_MODE_MSB:`TCCM_PRELOAD_BIT] :
                       regWdata[`TCCM_MODE_MSB:`TCCM_PRELOAD_BIT],
            regWdata[`TCCM_FAST_BIT],
            dirOpen ? regWdata[`TCCM_DIR_MSB:`TCCM_DIR_LSB] :
                      cfgReg[i][`TCCM_DIR_MSB:`TCCM_DIR_LSB]};

         // stored byte; filter bits act at once from here
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               cfgReg[i] <= `TCCM_CFG_RESET;
            end else if (wrHit) begin
               cfgReg[i] <= next_cfg;
            end
         end

         // ---- active mode (preload stage) ----
         // copy on commutation
         assign next_mode = (!timerStat.controlPreloadSelect ||
            timerStat.commutationEvent) ? outCfg.compareMode : activeMode;

         // mode lags the stored field by one cycle when not held
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               activeMode <= TCCM_FROZEN;
               prevMode <= TCCM_FROZEN;
            end else begin
               activeMode <= next_mode;
               prevMode <= activeMode;
            end
         end

         // ---- compare value and its preload ----
         // preload or direct
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               preloadCmp <= 16'h0000;
               activeCompare[i] <= 16'h0000;
            end else begin
               if (cmpWr[i]) begin
                  preloadCmp <= cmpWdata;
               end
               if (cmpWr[i] && !outCfg.comparePreloadEn) begin
                  activeCompare[i] <= cmpWdata;
               end else if (timerStat.updateEvent) begin
                  activeCompare[i] <= preloadCmp;
               end
            end
         end
         // software reads the preload while it is enabled
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               compareReadback[i] <= 16'h0000;
            end else begin
               compareReadback[i] <= outCfg.comparePreloadEn ?
                  preloadCmp : activeCompare[i];
            end
         end

         // ---- compare reference ----
         wire isOut = (outCfg.directionSelect == `TCCM_DIR_OUT);
         wire match = (timerStat.counterValue == activeCompare[i]);
         wire below = (timerStat.counterValue < activeCompare[i]);
         wire above = (timerStat.counterValue > activeCompare[i]);
         wire pwm1Lvl = timerStat.countDown ? !above : below;
         wire pwmLvl = (activeMode == TCCM_PWM2) ? !pwm1Lvl : pwm1Lvl;
         wire isPwm = (activeMode == TCCM_PWM1) || (activeMode == TCCM_PWM2);
         wire fastHit = trigPipe[`TCCM_FAST_DELAY-2] &&
            outCfg.fastTriggerEn && isPwm;
         wire pwmMove = (pwmLvl != lastPwm) || (prevMode == TCCM_FROZEN);

         always_comb begin
            next_ref = refLvl;
            unique case (activeMode)
               TCCM_FROZEN: next_ref = refLvl;
               TCCM_MATCH_HIGH: next_ref = match ? 1'b1 : refLvl;
               TCCM_MATCH_LOW: next_ref = match ? 1'b0 : refLvl;
               TCCM_TOGGLE: next_ref = match ? !refLvl : refLvl;
               TCCM_FORCE_LOW: next_ref = 1'b0;
               TCCM_FORCE_HIGH: next_ref = 1'b1;
               TCCM_PWM1, TCCM_PWM2: begin
                  if (fastHit) begin
                     next_ref = (activeMode == TCCM_PWM2);
                  end else if (pwmMove) begin
                     next_ref = pwmLvl;
                  end
               end
            endcase
            if (outCfg.extClearEn && timerStat.filteredExternalTrigger) begin
               next_ref = 1'b0;
            end
         end

         // reference only runs while the channel is an output
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               refLvl <= 1'b0;
               lastPwm <= 1'b0;
            end else if (isOut) begin
               refLvl <= next_ref;
               lastPwm <= pwmLvl;
            end
         end
         assign compareReference[i] = refLvl;

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               chOutput[i] <= 1'b0;
            end else begin
               chOutput[i] <= isOut && chanEn[i].enable &&
                  (next_ref ^ chanEn[i].polarity);
            end
         end

         // ---- input filter ----
         // rate and length by code
         wire sampleEn =
            ((divCnt & tccm_filter_mask(inCfg.inputFilter)) == 5'h00);
         wire [3:0] filtLen = tccm_filter_len(inCfg.inputFilter);

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               filtCnt <= 4'h0;
               filteredInput[i] <= 1'b0;
            end else if (pinSync[i] == filteredInput[i]) begin
               filtCnt <= 4'h0;
            end else if (sampleEn) begin
               if (filtCnt == filtLen - 4'h1) begin
                  filteredInput[i] <= pinSync[i];
                  filtCnt <= 4'h0;
               end else begin
                  filtCnt <= filtCnt + 4'h1;
               end
            end
         end

         // ---- capture source and prescaler ----
         // source by direction
         // channel 2 code 11 has no source
         wire capSrc =
            (inCfg.directionSelect == `TCCM_DIR_OWN) ? filteredInput[i] :
            (inCfg.directionSelect == `TCCM_DIR_OTHER) ?
               filteredInput[1-i] :
            (i == 0) && timerStat.internalTriggerSelected &&
               timerStat.internalTriggerInput;
         wire isIn = (inCfg.directionSelect != `TCCM_DIR_OUT);
         wire capEdge = isIn && chanEn[i].enable &&
            (chanEn[i].polarity ? (srcPrev && !capSrc) :
                                  (!srcPrev && capSrc));
         // every 1, 2, 4 or 8
         wire [2:0] pscLast = 3'((4'h1 << inCfg.capturePrescale) - 4'h1);
         // a count left from a larger ratio still closes the group,
         // so lowering the ratio on the fly never skips eight events
         wire pscFull = (pscCnt >= pscLast);

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               srcPrev <= 1'b0;
               pscCnt <= 3'h0;
               capturePulse[i] <= 1'b0;
            end else begin
               srcPrev <= capSrc;
               capturePulse[i] <= capEdge && pscFull;
               if (!chanEn[i].enable) begin
                  pscCnt <= 3'h0;
               end else if (capEdge) begin
                  pscCnt <= pscFull ? 3'h0 : pscCnt + 3'h1;
               end
            end
         end
      end
   endgenerate

   // software keeps preload on in PWM
   // filter read straight from stored byte
   // channel 2 shares the generated logic

endmodule // tccm_mode_config

/* File: tccm_mode_config_checker.sv */
`timescale 1ns/100ps
module tccm_mode_config_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   // compare path and timer status
   input wire logic [1:0] cmpWr,
   input wire logic [15:0] cmpWdata,
   input wire logic [1:0][15:0] activeCompare,
   input wire tccm_pkg::tccm_timer_t timerStat,
   input wire tccm_pkg::tccm_chan_en_t [1:0] chanEn,
   // channel results
   input wire logic [1:0] compareReference,
   input wire logic [1:0] chOutput
);
   import tccm_pkg::*;
   // ----
   // shadow of the channel 1 mode byte
   // ----
   logic [7:0] cfg1; // value software should read back
   logic [7:0] next_cfg1;
   // mode and preload bits frozen by full lock on an output
   wire lockOut = timerStat.lockLevel == 2'h3 && cfg1[1:0] == 2'h0;
   assign next_cfg1 = {regWdata[7], lockOut ? cfg1[6:3] : regWdata[6:3],
      regWdata[2], chanEn[0].enable ? cfg1[1:0] : regWdata[1:0]};
   // direction bits only move while the channel is off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg1 <= 8'h00;
      end else if (regWr && regAddr == 8'h08) begin
         cfg1 <= next_cfg1;
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ----
   // assertions; four stable edges let the active mode catch up
   // ----
   rd_back_a: assert property (
      regRd && regAddr == 8'h08 |=> regRdata == $past(cfg1))
      else $error("mode byte read back wrong");
   clear_ref_a: assert property (
      cfg1[7] && cfg1 == $past(cfg1, 4) && cfg1[1:0] == 2'h0
      && timerStat.filteredExternalTrigger |=> !compareReference[0])
      else $error("reference not cleared by external trigger");
   frozen_ref_a: assert property (
      cfg1[7:4] == 4'h0 && cfg1[1:0] == 2'h0 && cfg1 == $past(cfg1, 4)
      && !timerStat.controlPreloadSelect |=> $stable(compareReference[0]))
      else $error("frozen reference moved");
   force_low_a: assert property (
      cfg1[6:4] == 3'h4 && cfg1[1:0] == 2'h0 && cfg1 == $past(cfg1, 4)
      && !timerStat.controlPreloadSelect |-> !compareReference[0])
      else $error("forced low reference is high");
   cmp_direct_a: assert property (
      cmpWr[0] && !cfg1[3] |=> activeCompare[0] == $past(cmpWdata))
      else $error("direct compare write not taken");
   cmp_hold_a: assert property (
      cfg1[3] && $past(cfg1[3], 2) && !timerStat.updateEvent
      |=> $stable(activeCompare[0]))
      else $error("preloaded compare moved without update");
   out_pol_a: assert property (
      chOutput[0] |-> $past(chanEn[0].enable)
      && compareReference[0] != $past(chanEn[0].polarity))
      else $error("channel 1 output level wrong");
   out_pol2_a: assert property (
      chOutput[1] |-> $past(chanEn[1].enable)
      && compareReference[1] != $past(chanEn[1].polarity))
      else $error("channel 2 output level wrong");
endmodule // tccm_mode_config_checker

/* File: tb_tccm_mode_config.sv */
`timescale 1ns/100ps
module tb_tccm_mode_config;
   import tccm_pkg::*;
   // ----
   // signals and counters
   // ----
   logic clk;
   logic rstn;
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic regWr;
   logic regRd;
   logic [7:0] regRdata;
   logic [1:0] cmpWr;
   logic [15:0] cmpWdata;
   logic [1:0][15:0] compareReadback;
   logic [1:0][15:0] activeCompare;
   tccm_timer_t ts; // timer core status, driven by hand
   tccm_chan_en_t [1:0] chanEn;
   logic [1:0] chPin;
   logic [1:0] compareReference;
   logic [1:0] chOutput;
   logic [1:0] capturePulse;
   logic [1:0] filteredInput;
   int numErrors;
   int checked;
   tccm_mode_config i_tccm_mode_config (.clk(clk), .rstn(rstn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .cmpWr(cmpWr), .cmpWdata(cmpWdata),
      .compareReadback(compareReadback), .activeCompare(activeCompare),
      .timerStat(ts), .chanEn(chanEn), .chPin(chPin),
      .compareReference(compareReference), .chOutput(chOutput),
      .filteredInput(filteredInput), .capturePulse(capturePulse));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ----
   // shared tasks
   // ----
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // one-cycle write strobe on the register port
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chk("regRdata", 16'(regRdata), 16'(e));
   endtask
   task automatic setCmp(logic [15:0] v);
      @(posedge clk);
      cmpWr <= 2'b01;
      cmpWdata <= v;
      @(posedge clk);
      cmpWr <= 2'b00;
   endtask
   // counter meets the compare value for exactly one edge
   task automatic hit(logic [15:0] v);
      @(posedge clk);
      ts.counterValue <= v;
      @(posedge clk);
      ts.counterValue <= v + 16'h0001;
      cyc(2);
   endtask
   // k pin pulses w cycles wide, capture pulses counted
   task automatic edges(int k, int w, output int n);
      n = 0;
      for (int j = 0; j < 12 * k; j++) begin
         @(posedge clk);
         chPin[0] <= (j % 12) < w;
         @(negedge clk);
         n += int'(capturePulse[0] === 1'b1);
      end
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_regs();
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'h00);
      @(posedge clk) chanEn[0] <= 3'b001;
      wr(8'h08, 8'h01);
      rd(8'h08, 8'h00);
      @(posedge clk) chanEn[0] <= 3'b000;
      for (int d = 0; d < 4; d++) begin
         wr(8'h08, 8'(d));
         rd(8'h08, 8'(d));
         wr(8'h09, 8'(d));
         rd(8'h09, 8'(d));
      end
      // either enable of channel 2 blocks its direction
      @(posedge clk) chanEn[1] <= 3'b100;
      wr(8'h09, 8'h01);
      rd(8'h09, 8'h03);
      @(posedge clk) chanEn[1] <= 3'b001;
      wr(8'h09, 8'h01);
      rd(8'h09, 8'h03);
      @(posedge clk) chanEn[1] <= 3'b000;
      wr(8'h09, 8'h00);
      wr(8'h08, 8'h00);
      // full lock only bites while the stored direction is output
      @(posedge clk) ts.lockLevel <= 2'h3;
      wr(8'h08, 8'hF9);
      rd(8'h08, 8'h81);
      wr(8'h08, 8'h79);
      rd(8'h08, 8'h79);
      wr(8'h08, 8'h00);
      @(posedge clk) ts.lockLevel <= 2'h0;
   endtask
   task automatic t_modes();
      logic [2:0] md [7];
      logic [0:6] ex = 7'b1101010;
      md = '{3'h5, 3'h0, 3'h2, 3'h1, 3'h3, 3'h3, 3'h4};
      @(posedge clk) chanEn[0] <= 3'b001;
      setCmp(16'h0100);
      @(negedge clk);
      chk("activeCompare", activeCompare[0], 16'h0100);
      for (int i = 0; i < 7; i++) begin
         wr(8'h08, {1'b0, md[i], 4'h0});
         cyc(4);
         hit(16'h0100);
         chk("ref", 16'(compareReference[0]), 16'(ex[i]));
      end
      wr(8'h08, 8'h50);
      cyc(4);
      chk("chOutput", 16'(chOutput[0]), 16'h0001);
      @(posedge clk) chanEn[0] <= 3'b011;
      cyc(2);
      chk("chOutput", 16'(chOutput[0]), 16'h0000);
      @(posedge clk) chanEn[1] <= 3'b001;
      wr(8'h09, 8'h50);
      cyc(4);
      chk("chOutput2", 16'(chOutput[1]), 16'h0001);
      // clear enable overrides even a forced high
      wr(8'h08, 8'hD0);
      @(posedge clk) ts.filteredExternalTrigger <= 1'b1;
      cyc(4);
      chk("clearRef", 16'(compareReference[0]), 16'h0000);
      wr(8'h08, 8'h50);
      cyc(4);
      chk("clearRef", 16'(compareReference[0]), 16'h0001);
      @(posedge clk) ts.filteredExternalTrigger <= 1'b0;
      // preload-controlled mode waits for a commutation event
      @(posedge clk) ts.controlPreloadSelect <= 1'b1;
      wr(8'h08, 8'h40);
      cyc(4);
      chk("comMode", 16'(compareReference[0]), 16'h0001);
      @(posedge clk) ts.commutationEvent <= 1'b1;
      @(posedge clk) ts.commutationEvent <= 1'b0;
      cyc(1);
      chk("comMode", 16'(compareReference[0]), 16'h0000);
      @(posedge clk) ts.controlPreloadSelect <= 1'b0;
      // the first pwm mode below is entered from frozen
      wr(8'h08, 8'h00);
   endtask
   // table entries: level, mode, count down, counter above compare
   task automatic t_pwm();
      logic [5:0] pw [7];
      pw = '{6'h38, 6'h19, 6'h1C, 6'h3D, 6'h1E, 6'h1B, 6'h3A};
      foreach (pw[i]) begin
         @(posedge clk);
         ts.countDown <= pw[i][1];
         ts.counterValue <= pw[i][0] ? 16'h0180 : 16'h0080;
         wr(8'h08, {1'b0, pw[i][4:2], 4'h8});
         cyc(4);
         chk("pwmRef", 16'(compareReference[0]), 16'(pw[i][5]));
      end
      // fast trigger forces the match level against the comparison
      @(posedge clk) ts.countDown <= 1'b0;
      wr(8'h08, 8'h6C);
      cyc(4);
      chk("fastRef", 16'(compareReference[0]), 16'h0001);
      @(posedge clk) ts.triggerEdge <= 1'b1;
      @(posedge clk) ts.triggerEdge <= 1'b0;
      cyc(1);
      chk("fastRef", 16'(compareReference[0]), 16'h0001);
      cyc(1);
      chk("fastRef", 16'(compareReference[0]), 16'h0000);
      setCmp(16'h0200);
      cyc(1);
      chk("activeCompare", activeCompare[0], 16'h0100);
      chk("readback", compareReadback[0], 16'h0200);
      @(posedge clk) ts.updateEvent <= 1'b1;
      @(posedge clk) ts.updateEvent <= 1'b0;
      @(negedge clk);
      chk("activeCompare", activeCompare[0], 16'h0200);
   endtask
   // table entries: filter code, pulse width, captures expected
   task automatic t_capture();
      int n;
      logic [11:0] fl [5];
      fl = '{12'h022, 12'h220, 12'h262, 12'h360, 12'h460};
      for (int p = 0; p < 4; p++) begin
         @(posedge clk) chanEn[0] <= 3'b000;
         wr(8'h08, {4'h0, 2'(p), 2'h1});
         @(posedge clk) chanEn[0] <= 3'b001;
         edges(8, 6, n);
         chk("captures", 16'(n), 16'(8 >> p));
      end
      @(posedge clk) chanEn[0] <= 3'b000;
      wr(8'h08, 8'h05);
      @(posedge clk) chanEn[0] <= 3'b001;
      edges(1, 6, n);
      @(posedge clk) chanEn[0] <= 3'b000;
      @(posedge clk) chanEn[0] <= 3'b001;
      edges(1, 6, n);
      chk("captures", 16'(n), 16'h0000);
      foreach (fl[i]) begin
         wr(8'h08, {fl[i][11:8], 4'h1});
         edges(2, int'(fl[i][7:4]), n);
         chk("filtered", 16'(n), 16'(fl[i][3:0]));
      end
      // code 0: two sync stages plus one filter flop
      wr(8'h08, 8'h01);
      @(posedge clk) chPin[0] <= 1'b1;
      cyc(2);
      chk("filteredInput", 16'(filteredInput[0]), 16'h0000);
      cyc(1);
      chk("filteredInput", 16'(filteredInput[0]), 16'h0001);
      @(posedge clk) chPin[0] <= 1'b0;
   endtask
   task automatic results();
      $display("checked %0d numErrors %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // main sequence, everything driven from time zero
   initial begin
      rstn = 1'b0;
      {regAddr, regWdata, regWr, regRd, cmpWr, cmpWdata} = '0;
      ts = '0;
      chanEn = '0;
      chPin = 2'h0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_modes();
      t_pwm();
      t_capture();
      results();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      numErrors++;
      results();
   end
endmodule // tb_tccm_mode_config
bind tccm_mode_config tccm_mode_config_checker i_tccm_mode_config_checker (
   .clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .cmpWr,
   .cmpWdata, .activeCompare, .timerStat, .chanEn, .compareReference,
   .chOutput);
